// file: rtl/ifr_cfg.svh
// Purpose: Register indices, bit positions and reset values of the interrupt register set
// Assumes: Included by the package and the design module
// Notes: Register indices are the values driven on the special-register address port
`ifndef IFR_CFG_SVH
`define IFR_CFG_SVH

// ----------------------------------------------------------------
// Register select
// ----------------------------------------------------------------
`define IFR_ADDR_W 3
`define IFR_REG_EDGE 3'h0
`define IFR_REG_CTRL0 3'h1
`define IFR_REG_CTRL1 3'h2
`define IFR_REG_CTRL2 3'h3
`define IFR_REG_CTRL3 3'h4

// ----------------------------------------------------------------
// Source numbering, also the order of priority (0 highest)
// ----------------------------------------------------------------
`define IFR_NSRC 12
`define IFR_SRC_W 4
`define IFR_SRC_EXT 0
`define IFR_SRC_TOUCH 1
`define IFR_SRC_TB0 2
`define IFR_GRP1_BASE 3
`define IFR_GRP2_BASE 7
`define IFR_SRC_LVD 11
`define IFR_NO_SRC 4'hF

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define IFR_EDGE_HI 1
`define IFR_EDGE_LO 0
`define IFR_C0_TIMEBASE0_FLAG 6
`define IFR_C0_TKF 5
`define IFR_C0_EXTF 4
`define IFR_C0_TIMEBASE0_ENABLE 3
`define IFR_C0_TKE 2
`define IFR_C0_EXTE 1
`define IFR_C0_GIE 0
`define IFR_GRP_FLAG_TOP 7
`define IFR_GRP_EN_TOP 3
`define IFR_GRP_SIZE 4
`define IFR_C3_LOWVOLT_FLAG 4
`define IFR_C3_LOWVOLT_ENABLE 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IFR_RST_BYTE 8'h00
`define IFR_RST_SRC 12'h000
`define IFR_RST_EDGE 2'h0

`endif

// file: rtl/ifr_pkg.sv
// Purpose: Types shared by the interrupt register set
// Assumes: Nothing beyond the cfg header
// Notes: Edge modes follow the order of the two-bit selector codes
`default_nettype none
`include "ifr_cfg.svh"

package ifr_pkg;
  typedef logic [7:0] ifr_byte_t;
  typedef logic [`IFR_NSRC-1:0] ifr_src_vec_t;
  typedef enum logic [1:0] {IFR_EDGE_OFF, IFR_EDGE_RISE, IFR_EDGE_FALL, IFR_EDGE_BOTH} ifr_edge_t;
endpackage

`default_nettype wire

// file: rtl/ifr_regs.sv
// Purpose: Interrupt flag, enable, global enable and pin edge-select registers
// Assumes: Event inputs are one-cycle pulses on clk_sys; the pin is asynchronous
// Notes: Register reads answer one clock after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "ifr_cfg.svh"

module ifr_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ext_pin,
  input wire logic [`IFR_NSRC-2:0] periph_event,
  input wire logic [`IFR_ADDR_W-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire ifr_pkg::ifr_byte_t sfr_wdata,
  output var ifr_pkg::ifr_byte_t sfr_rdata,
  input wire logic irq_ack,
  input wire logic [`IFR_SRC_W-1:0] irq_ack_src,
  output logic irq_req,
  output logic [`IFR_SRC_W-1:0] irq_src,
  output logic global_irq_enable
);
  import ifr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ifr_src_vec_t flag, next_flag;
  ifr_src_vec_t enable, next_enable;
  logic [1:0] edge_sel, next_edge_sel;
  logic next_gie;
  logic next_irq_req;
  logic [`IFR_SRC_W-1:0] next_irq_src;
  ifr_byte_t next_rdata;
  logic ext_s1, ext_s2, ext_s3;
  logic ext_hit;
  ifr_src_vec_t set_vec;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`IFR_SRC_W-1:0] pick_src(input ifr_src_vec_t pend);
    logic [`IFR_SRC_W-1:0] res;
    res = `IFR_NO_SRC;
    for (int i = `IFR_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        res = `IFR_SRC_W'(i);
      end
    end
    return res;
  endfunction

  function automatic ifr_byte_t read_reg(input logic [`IFR_ADDR_W-1:0] addr,
                                         input ifr_src_vec_t f, input ifr_src_vec_t e,
                                         input logic gie, input logic [1:0] es);
    ifr_byte_t r;
    r = `IFR_RST_BYTE;
    unique case (addr)
      `IFR_REG_EDGE: begin
        r[`IFR_EDGE_HI:`IFR_EDGE_LO] = es;
      end
      `IFR_REG_CTRL0: begin
        r[`IFR_C0_TIMEBASE0_FLAG] = f[`IFR_SRC_TB0];
        r[`IFR_C0_TKF] = f[`IFR_SRC_TOUCH];
        r[`IFR_C0_EXTF] = f[`IFR_SRC_EXT];
        r[`IFR_C0_TIMEBASE0_ENABLE] = e[`IFR_SRC_TB0];
        r[`IFR_C0_TKE] = e[`IFR_SRC_TOUCH];
        r[`IFR_C0_EXTE] = e[`IFR_SRC_EXT];
        r[`IFR_C0_GIE] = gie;
      end
      `IFR_REG_CTRL1, `IFR_REG_CTRL2: begin
        for (int k = 0; k < `IFR_GRP_SIZE; k++) begin
          if (addr == `IFR_REG_CTRL1) begin
            r[`IFR_GRP_FLAG_TOP-k] = f[`IFR_GRP1_BASE+k];
            r[`IFR_GRP_EN_TOP-k] = e[`IFR_GRP1_BASE+k];
          end else begin
            r[`IFR_GRP_FLAG_TOP-k] = f[`IFR_GRP2_BASE+k];
            r[`IFR_GRP_EN_TOP-k] = e[`IFR_GRP2_BASE+k];
          end
        end
      end
      `IFR_REG_CTRL3: begin
        r[`IFR_C3_LOWVOLT_FLAG] = f[`IFR_SRC_LVD];
        r[`IFR_C3_LOWVOLT_ENABLE] = e[`IFR_SRC_LVD];
      end
      default: begin
        r = `IFR_RST_BYTE;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  always_comb begin
    unique case (ifr_edge_t'(edge_sel))
      IFR_EDGE_OFF: ext_hit = 1'b0;
      IFR_EDGE_RISE: ext_hit = ext_s2 & ~ext_s3;
      IFR_EDGE_FALL: ext_hit = ~ext_s2 & ext_s3;
      IFR_EDGE_BOTH: ext_hit = ext_s2 ^ ext_s3;
    endcase
    set_vec = {periph_event, ext_hit};
  end

  // ----------------------------------------------------------------
  // Register file next values
  // ----------------------------------------------------------------
  always_comb begin
    next_flag = flag;
    next_enable = enable;
    next_gie = global_irq_enable;
    next_edge_sel = edge_sel;
    if (sfr_wr) begin
      unique case (sfr_addr)
        `IFR_REG_EDGE: begin
          next_edge_sel = sfr_wdata[`IFR_EDGE_HI:`IFR_EDGE_LO];
        end
        `IFR_REG_CTRL0: begin
          next_flag[`IFR_SRC_TB0] = sfr_wdata[`IFR_C0_TIMEBASE0_FLAG];
          next_flag[`IFR_SRC_TOUCH] = sfr_wdata[`IFR_C0_TKF];
          next_flag[`IFR_SRC_EXT] = sfr_wdata[`IFR_C0_EXTF];
          next_enable[`IFR_SRC_TB0] = sfr_wdata[`IFR_C0_TIMEBASE0_ENABLE];
          next_enable[`IFR_SRC_TOUCH] = sfr_wdata[`IFR_C0_TKE];
          next_enable[`IFR_SRC_EXT] = sfr_wdata[`IFR_C0_EXTE];
          next_gie = sfr_wdata[`IFR_C0_GIE];
        end
        `IFR_REG_CTRL1: begin
          for (int k = 0; k < `IFR_GRP_SIZE; k++) begin
            next_flag[`IFR_GRP1_BASE+k] = sfr_wdata[`IFR_GRP_FLAG_TOP-k];
            next_enable[`IFR_GRP1_BASE+k] = sfr_wdata[`IFR_GRP_EN_TOP-k];
          end
        end
        `IFR_REG_CTRL2: begin
          for (int k = 0; k < `IFR_GRP_SIZE; k++) begin
            next_flag[`IFR_GRP2_BASE+k] = sfr_wdata[`IFR_GRP_FLAG_TOP-k];
            next_enable[`IFR_GRP2_BASE+k] = sfr_wdata[`IFR_GRP_EN_TOP-k];
          end
        end
        `IFR_REG_CTRL3: begin
          next_flag[`IFR_SRC_LVD] = sfr_wdata[`IFR_C3_LOWVOLT_FLAG];
          next_enable[`IFR_SRC_LVD] = sfr_wdata[`IFR_C3_LOWVOLT_ENABLE];
        end
        default: begin
          next_gie = global_irq_enable;
        end
      endcase
    end
    // Taking an interrupt clears its flag and blocks nesting
    if (irq_ack) begin
      next_gie = 1'b0;
      if (irq_ack_src < `IFR_SRC_W'(`IFR_NSRC)) begin
        next_flag[irq_ack_src] = 1'b0;
      end
    end
    // New events win over any clear in the same cycle
    next_flag = next_flag | set_vec;
    next_irq_req = next_gie & (|(next_flag & next_enable));
    next_irq_src = pick_src(next_flag & next_enable);
    next_rdata = sfr_rd ? read_reg(sfr_addr, flag, enable, global_irq_enable, edge_sel)
                        : sfr_rdata;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag <= `IFR_RST_SRC;
      enable <= `IFR_RST_SRC;
      global_irq_enable <= 1'b0;
      edge_sel <= `IFR_RST_EDGE;
      irq_req <= 1'b0;
      irq_src <= `IFR_NO_SRC;
      sfr_rdata <= `IFR_RST_BYTE;
    end else begin
      flag <= next_flag;
      enable <= next_enable;
      global_irq_enable <= next_gie;
      edge_sel <= next_edge_sel;
      irq_req <= next_irq_req;
      irq_src <= next_irq_src;
      sfr_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_edge_off_quiet: assert property ((edge_sel == 2'b00) && !sfr_wr |=> !$rose(flag[0]))
    else $error("pin flag set while edge detection is off");
  a_edge_rise_sets: assert property ((edge_sel == 2'b01) && ext_s2 && !ext_s3 |=> flag[0])
    else $error("rising pin edge not recorded");
  a_edge_read_zero: assert property (sfr_rd && (sfr_addr == `IFR_REG_EDGE)
    |=> sfr_rdata[7:2] == 6'h00 && sfr_rdata[1:0] == $past(edge_sel))
    else $error("edge register read wrong");
  a_ctrl0_write: assert property (sfr_wr && (sfr_addr == `IFR_REG_CTRL0) && !irq_ack
    |=> enable[`IFR_SRC_EXT] == $past(sfr_wdata[1])
    && global_irq_enable == $past(sfr_wdata[0]))
    else $error("control 0 write not applied");
  a_ctrl1_order: assert property (sfr_wr && (sfr_addr == `IFR_REG_CTRL1)
    |=> enable[3] == $past(sfr_wdata[3]) && enable[6] == $past(sfr_wdata[0]))
    else $error("control 1 enable order wrong");
  a_event_recorded: assert property ((periph_event != 11'h000)
    |=> (flag[11:1] & $past(periph_event)) == $past(periph_event))
    else $error("peripheral event lost");
  a_ctrl2_read: assert property (sfr_rd && (sfr_addr == `IFR_REG_CTRL2)
    |=> sfr_rdata[7] == $past(flag[7]) && sfr_rdata[0] == $past(enable[10]))
    else $error("control 2 read layout wrong");
  a_ctrl3_zeros: assert property (sfr_rd && (sfr_addr == `IFR_REG_CTRL3)
    |=> (sfr_rdata & 8'hEE) == 8'h00)
    else $error("control 3 unused bits not zero");
  a_req_masked: assert property (irq_req |-> global_irq_enable && |(flag & enable))
    else $error("request without enable");
  // A write may drop the request legally, so only quiet cycles must keep it
  a_req_raised: assert property (global_irq_enable && |(flag & enable)
    && !irq_ack && !sfr_wr |=> irq_req)
    else $error("enabled request not raised");
  a_ack_blocks: assert property (irq_ack ##1 !sfr_wr [*2] |-> !global_irq_enable && !irq_req)
    else $error("nesting not blocked after acknowledge");
  a_reset_clear: assert property ($past(sys_rst) |-> flag == 12'h000 && enable == 12'h000
    && edge_sel == 2'b00 && !global_irq_enable)
    else $error("state not cleared by reset");

  c_pin_irq: cover property ((edge_sel == 2'b01) && ext_hit ##1 irq_req);
  c_ack_taken: cover property (irq_req ##1 irq_ack ##1 !global_irq_enable);
  c_both_edges: cover property ((edge_sel == 2'b11) && ext_hit ##[1:20] ext_hit);
endmodule

`default_nettype wire

// file: dv/ifr_src_model.sv
// Purpose: Peripheral event sources and core acknowledge model
// Assumes: Events are one-cycle pulses on clk_sys
// Notes: Core takes a request after ack_delay cycles while ack_en is high
`timescale 1ns/1ps
`default_nettype none
`include "ifr_cfg.svh"
module ifr_src_model (
  input wire logic clk_sys,
  input wire logic irq_req,
  input wire logic [`IFR_SRC_W-1:0] irq_src,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  output logic ext_pin,
  output logic [`IFR_NSRC-2:0] periph_event,
  output logic irq_ack,
  output logic [`IFR_SRC_W-1:0] irq_ack_src
);
  logic [3:0] wait_cnt;
  initial begin
    ext_pin = 1'b0;
    periph_event = '0;
    irq_ack = 1'b0;
    irq_ack_src = `IFR_NO_SRC;
    wait_cnt = 4'h0;
  end
  // One acknowledge per request; the guard skips the cycle the request is still seen high
  always @(posedge clk_sys) begin
    irq_ack <= 1'b0;
    irq_ack_src <= `IFR_NO_SRC;
    if (ack_en && irq_req && !irq_ack) begin
      if (wait_cnt == ack_delay) begin
        irq_ack <= 1'b1;
        irq_ack_src <= irq_src;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
  task automatic pulse(input int idx);
    @(posedge clk_sys);
    periph_event[idx] <= 1'b1;
    @(posedge clk_sys);
    periph_event <= '0;
  endtask
  task automatic pin(input logic v);
    @(posedge clk_sys);
    ext_pin <= v;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_interrupt_flag_enable_regs.sv
// Purpose: Self-checking bench of the interrupt register set
// Assumes: Source model drives events and acknowledges
// Notes: Read data is sampled two edges after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "ifr_cfg.svh"
module tb_interrupt_flag_enable_regs;
  import ifr_pkg::*;
  logic clk_sys, sys_rst, sfr_wr, sfr_rd, irq_req, global_irq_enable, ext_pin, irq_ack, ack_en;
  logic [2:0] sfr_addr;
  ifr_byte_t sfr_wdata, sfr_rdata;
  logic [3:0] irq_src, irq_ack_src, ack_delay;
  logic [10:0] periph_event;
  int err_count, num_checks;
  logic [7:0] mask [8] = '{8'h03, 8'h7F, 8'hFF, 8'hFF, 8'h11, 8'h00, 8'h00, 8'h00};
  ifr_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ext_pin(ext_pin),
    .periph_event(periph_event), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_ack(irq_ack), .irq_ack_src(irq_ack_src),
    .irq_req(irq_req), .irq_src(irq_src), .global_irq_enable(global_irq_enable));
  ifr_src_model src (.clk_sys(clk_sys), .irq_req(irq_req), .irq_src(irq_src), .ack_en(ack_en),
    .ack_delay(ack_delay), .ext_pin(ext_pin), .periph_event(periph_event), .irq_ack(irq_ack),
    .irq_ack_src(irq_ack_src));
  always #10 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    #1 check(sfr_rdata, exp);
  endtask
  // Bounded wait for a raised request or for the global enable to drop
  task automatic wait_on(input bit want_req);
    for (int i = 0; i < 20; i++) begin
      #1;
      if (want_req ? irq_req === 1'b1 : global_irq_enable === 1'b0) return;
      @(posedge clk_sys);
    end
    err_count++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    sfr_addr = 3'h0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    ack_en = 1'b0;
    ack_delay = 4'h3;
    err_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    for (int a = 0; a < 8; a++) begin
      wr(a[2:0], 8'hFF);
      rd(a[2:0], mask[a]);
      wr(a[2:0], 8'h00);
    end
    $display("Test readback done");
    for (int s = 1; s < 12; s++) begin
      logic [2:0] ad;
      int b;
      ad = (s < 3) ? 3'h1 : (s < 7) ? 3'h2 : (s < 11) ? 3'h3 : 3'h4;
      b = (s == 1) ? 5 : (s == 2) ? 6 : (s == 11) ? 4 : 7 - ((s - 3) % 4);
      src.pulse(s - 1);
      @(posedge clk_sys);
      #1 check({7'h00, irq_req}, 8'h00);
      rd(ad, 8'h01 << b);
      wr(ad, 8'h00);
    end
    $display("Test event flags done");
    wr(3'h1, 8'h04);
    src.pulse(0);
    repeat (2) @(posedge clk_sys);
    #1 check({7'h00, irq_req}, 8'h00);
    rd(3'h1, 8'h24);
    ack_en <= 1'b1;
    wr(3'h1, 8'h37);
    wait_on(1'b1);
    check({4'h0, irq_src}, 8'h00);
    wait_on(1'b0);
    @(posedge clk_sys);
    #1 check({7'h00, irq_req}, 8'h00);
    rd(3'h1, 8'h26);
    ack_delay <= 4'h9;
    wr(3'h1, 8'h27);
    wait_on(1'b1);
    check({4'h0, irq_src}, 8'h01);
    wait_on(1'b0);
    rd(3'h1, 8'h06);
    ack_en <= 1'b0;
    $display("Test acknowledge done");
    for (int m = 0; m < 4; m++) begin
      wr(3'h0, {6'h00, m[1:0]});
      wr(3'h1, 8'h03);
      src.pin(1'b1);
      repeat (6) @(posedge clk_sys);
      rd(3'h1, m[0] ? 8'h13 : 8'h03);
      check({7'h00, irq_req}, {7'h00, m[0]});
      wr(3'h1, 8'h00);
      src.pin(1'b0);
      repeat (6) @(posedge clk_sys);
      rd(3'h1, m[1] ? 8'h10 : 8'h00);
    end
    $display("Test pin edges done");
    conclude();
  end
endmodule
`default_nettype wire
